/* bench/pcgr_asserts.sv */
// Port-level checks of the clock gating register block.
// Assumes hready is fed back from hreadyout and one clock domain.
`timescale 1ns/1ns
`default_nettype none
module pcgr_asserts (
	// Clock and reset
	input wire logic                      clk_sys,
	input wire logic                      rst,
	// Bus side
	input wire logic                      ce,
	input wire logic                      hsel,
	input wire logic [1:0]                htrans,
	input wire logic                      hwrite,
	input wire logic                      hready,
	input wire logic                      hreadyout,
	input wire logic [31:0]               hrdata,
	input wire logic                      hresp,
	// Unit side
	input wire pcgr_pkg::pcgr_pwr_t       pwr_state,
	input wire pcgr_pkg::pcgr_acc_t       unit_acc,
	input wire logic                      unit_fault,
	input wire logic [pcgr_pkg::NUM_UNITS-1:0] clk_en,
	input wire logic                      irq
);
	import pcgr_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Transfer accepted by the slave
	wire logic take = hsel && htrans[1] && hready && ce;
	sequence s_take; take; endsequence
	sequence s_stall; !hreadyout ##1 hreadyout; endsequence
	property p_wait; s_take |=> s_stall; endproperty
	a_wait: assert property (p_wait) else $error("wait state wrong");
	property p_fault;
		unit_fault == (unit_acc.valid && unit_acc.unit < NUM_UNITS && !clk_en[unit_acc.unit]);
	endproperty
	a_fault: assert property (p_fault) else $error("fault answer wrong");
	property p_okay; hresp == 1'b0; endproperty
	a_okay: assert property (p_okay) else $error("response not okay");
	property p_rst_en; $fell(rst) |-> clk_en == '0 && !irq; endproperty
	a_rst_en: assert property (p_rst_en) else $error("enables set after reset");
	// Enables move only after a register write or a power state change
	property p_en_cause;
		!$stable(clk_en) |-> $past(take, 3) || $past(pwr_state) != $past(pwr_state, 2);
	endproperty
	a_en_cause: assert property (p_en_cause) else $error("enable moved unasked");
	property p_rd_hold; !$stable(hrdata) |-> $past(take && !hwrite, 2); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_irq_cause; $rose(irq) |-> $past(unit_fault) || $past(take, 2); endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq rose unasked");
	property p_irq_drop; $fell(irq) |-> $past(take, 2); endproperty
	a_irq_drop: assert property (p_irq_drop) else $error("irq fell unasked");
endmodule : pcgr_asserts
bind pcgr_top pcgr_asserts i_chk (.clk_sys, .rst, .ce, .hsel, .htrans, .hwrite, .hready,
	.hreadyout, .hrdata, .hresp, .pwr_state, .unit_acc, .unit_fault, .clk_en, .irq);
`default_nettype wire

/* bench/pcgr_unit_model.sv */
// Gated peripheral units: one-cycle accesses towards a chosen unit.
// Assumes requests come from the bench on clk_sys.
`timescale 1ns/1ns
`default_nettype none
module pcgr_unit_model (
	// Clock and request
	input wire logic                clk_sys,
	input wire logic                go,
	input wire logic [3:0]          unit,
	// Access towards the gating block
	output var pcgr_pkg::pcgr_acc_t acc = '0
);
	import pcgr_pkg::*;
	// A unit is touched only when software asks; idle index keeps toggling
	always @(posedge clk_sys) begin
		acc.valid <= go;
		acc.unit  <= go ? unit : ~acc.unit;
	end
endmodule : pcgr_unit_model
`default_nettype wire

/* bench/peripheral_clock_gating_regs_test.sv */
// Self-checking bench of the clock gating register block.
// Assumes the bench acts as sole AHB-Lite master.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
	$display("mismatch at %0t: got %h want %h", $time, a, b); end end
module peripheral_clock_gating_regs_test;
	import pcgr_pkg::*;
	// Bench-driven inputs
	logic clk_sys = 0, rst = 1, ce = 1, hsel = 0, hwrite = 0, go = 0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
	logic [3:0]  unit = 4'h0;
	pcgr_pwr_t   pwr_state = PCGR_PWR_RUN;
	pcgr_acc_t   acc;
	// Design outputs
	wire logic hreadyout, hresp, unit_fault, irq;
	wire logic [31:0] hrdata;
	wire logic [NUM_UNITS-1:0] clk_en;
	int n_errors = 0, tests_run = 0;
	// Rows: offset, data, write first, expected readback
	typedef struct { logic [11:0] a; logic [31:0] d; bit w; logic [31:0] e; } pcgr_row_t;
	pcgr_row_t rows [8] = '{
		'{OFF_RUN_G1, 32'h0, 0, 32'h0},
		'{OFF_DSL_G0, 32'h0, 0, 32'h40},
		'{OFF_SLP_G0, 32'h0, 0, 32'h40},
		'{OFF_RUN_G0, 32'hFFFFFFFF, 1, 32'h01000048},
		'{OFF_RUN_G1, 32'hFFFFFFFF, 1, 32'h030F0000},
		'{OFF_DSL_G0, 32'hFFFFFFFF, 1, 32'h01000048},
		'{OFF_DSL_G0, 32'h0, 1, 32'h0},
		'{12'h200, 32'hFFFFFFFF, 1, 32'h0}};
	pcgr_top i_dut (.clk_sys, .rst, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hrdata, .hresp, .pwr_state, .unit_acc(acc),
		.unit_fault, .clk_en, .irq);
	pcgr_unit_model i_units (.clk_sys, .go, .unit, .acc);
	always #5 clk_sys = ~clk_sys;
	// One single-word transfer; read data lands in rd
	task bus(input bit w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= BASE_ADDR | 32'(a);
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus
	// One access to a unit, fault checked while it stands
	task touch(input logic [3:0] u, input logic f);
		@(posedge clk_sys); go <= 1'b1; unit <= u;
		@(posedge clk_sys); go <= 1'b0;
		#1 `CHK(unit_fault, f)
		@(posedge clk_sys); #1;
	endtask : touch
	// Enables one edge after the cause
	task en_chk(input logic [NUM_UNITS-1:0] e);
		@(posedge clk_sys); #1 `CHK(clk_en, e)
	endtask : en_chk
	task wrap_up;
		$display("checks %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : wrap_up
	// Watchdog far beyond the hundred or so cycles needed
	initial begin
		#50000 n_errors++;
		$display("mismatch at %0t: timeout", $time);
		wrap_up;
	end
	initial begin
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		#1 `CHK(clk_en, 9'h0)
		foreach (rows[i]) begin
			if (rows[i].w) bus(1, rows[i].a, rows[i].d);
			bus(0, rows[i].a, 32'h0);
			`CHK(rd, rows[i].e)
		end
		$display("register rows done");
		en_chk(9'h1FF);
		bus(1, OFF_RUN_G1, 32'h02000000);
		en_chk(9'h107);
		// Masked-in fault raises irq; status read clears it
		bus(1, OFF_IRQ_MSK, 32'h3);
		touch(4'h3, 1'b1);
		`CHK(irq, 1'b1)
		touch(4'h8, 1'b0);
		touch(4'h9, 1'b0);
		bus(0, OFF_IRQ_STS, 32'h0);
		`CHK(rd, 32'h2)
		#1 `CHK(irq, 1'b0)
		// Masked-out fault still sets status
		bus(1, OFF_IRQ_MSK, 32'h0);
		touch(4'h3, 1'b1);
		`CHK(irq, 1'b0)
		bus(0, OFF_IRQ_STS, 32'h0);
		`CHK(rd, 32'h2)
		$display("fault and interrupt done");
		@(posedge clk_sys) pwr_state <= PCGR_PWR_DEEP;
		en_chk(9'h107);
		bus(1, OFF_RUN_CFG, 32'h1);
		en_chk(9'h0);
		touch(4'h2, 1'b1);
		bus(1, OFF_DSL_G0, 32'h01000008);
		en_chk(9'h005);
		@(posedge clk_sys) pwr_state <= PCGR_PWR_SLEEP;
		en_chk(9'h002);
		bus(0, OFF_IRQ_STS, 32'h0);
		`CHK(rd, 32'h1)
		// Frozen block: a fault seen while ce is low leaves the status clear
		@(posedge clk_sys) ce <= 1'b0;
		touch(4'h3, 1'b1);
		@(posedge clk_sys) ce <= 1'b1;
		bus(0, OFF_IRQ_STS, 32'h0);
		`CHK(rd, 32'h0)
		$display("power states done");
		// Reset spans two edges so no check compares across the asynchronous clear
		@(posedge clk_sys) rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		bus(0, OFF_DSL_G0, 32'h0);
		`CHK(rd, 32'h40)
		`CHK(clk_en, 9'h0)
		$display("second reset done");
		wrap_up;
	end
endmodule : peripheral_clock_gating_regs_test
`default_nettype wire

/* hdl/pcgr_pkg.sv */
// Constants, types and register map of the peripheral clock gating registers.
// Assumes one system clock and an AHB-Lite slave port in the system control space.
package pcgr_pkg;

	// System control space base; only the low 12 bits are decoded here
	localparam logic [31:0] BASE_ADDR     = 32'h400FE000;
	localparam int          REG_W         = 32;
	localparam int          OFF_W         = 12;

	// Register offsets
	localparam logic [11:0] OFF_RUN_G0    = 12'h100;
	localparam logic [11:0] OFF_RUN_G1    = 12'h104;
	localparam logic [11:0] OFF_SLP_G0    = 12'h110;
	localparam logic [11:0] OFF_SLP_G1    = 12'h114;
	localparam logic [11:0] OFF_DSL_G0    = 12'h120;
	localparam logic [11:0] OFF_DSL_G1    = 12'h124;
	localparam logic [11:0] OFF_RUN_CFG   = 12'h1E0;
	localparam logic [11:0] OFF_IRQ_STS   = 12'h1F0;
	localparam logic [11:0] OFF_IRQ_MSK   = 12'h1F4;

	// Unit bit positions in the group 0 registers
	localparam int          BIT_CAN       = 24;
	localparam int          BIT_DPD       = 6;
	localparam int          BIT_WDOG      = 3;
	// Unit bit positions in the group 1 registers
	localparam int          BIT_CMP_B     = 25;
	localparam int          BIT_CMP_A     = 24;
	localparam int          BIT_TMR_D     = 19;
	localparam int          BIT_TMR_C     = 18;
	localparam int          BIT_TMR_B     = 17;
	localparam int          BIT_TMR_A     = 16;

	// Writable bits per group; everything else is reserved
	localparam logic [31:0] G0_RW_MASK    = 32'h01000048;
	localparam logic [31:0] G1_RW_MASK    = 32'h030F0000;

	// Reset values
	localparam logic [31:0] RST_RUN_G0    = 32'h00000000;
	localparam logic [31:0] RST_RUN_G1    = 32'h00000000;
	localparam logic [31:0] RST_SLP_G0    = 32'h00000040;
	localparam logic [31:0] RST_SLP_G1    = 32'h00000000;
	localparam logic [31:0] RST_DSL_G0    = 32'h00000040;
	localparam logic [31:0] RST_DSL_G1    = 32'h00000000;

	// Run-mode clock configuration: auto clock gating bit
	localparam int          BIT_AUTO_GATE = 0;

	// Interrupt status bits: fault on a group 0 or group 1 unit
	localparam int          STS_W         = 2;
	localparam int          STS_FAULT_G0  = 0;
	localparam int          STS_FAULT_G1  = 1;

	// Gated units: order of the enable vector
	localparam int          NUM_GSETS     = 6;
	localparam int          NUM_UNITS     = 9;
	localparam int          UNIT_IDX_W    = 4;
	localparam int          UNIT_GRP [NUM_UNITS] = '{0, 0, 0, 1, 1, 1, 1, 1, 1};
	localparam int          UNIT_BIT [NUM_UNITS] = '{BIT_WDOG, BIT_DPD, BIT_CAN,
		BIT_TMR_A, BIT_TMR_B, BIT_TMR_C, BIT_TMR_D, BIT_CMP_A, BIT_CMP_B};

	// Power state of the processor
	typedef enum logic [1:0] {
		PCGR_PWR_RUN   = 2'b00,
		PCGR_PWR_SLEEP = 2'b01,
		PCGR_PWR_DEEP  = 2'b10
	} pcgr_pwr_t;

	// Access from the peripheral bus towards one gated unit
	typedef struct packed {
		logic                  valid;
		logic [UNIT_IDX_W-1:0] unit;
	} pcgr_acc_t;

endpackage : pcgr_pkg

/* hdl/pcgr_top.sv */
// Peripheral clock gating registers with AHB-Lite slave and per-unit clock enables.
// Assumes synchronous inputs on clk_sys and glitch-free gate cells fed by clk_en.
`timescale 1ns/1ns
`default_nettype none
module pcgr_top (
	// Clock, reset and clock enable
	input  wire logic                         clk_sys,
	input  wire logic                         rst,
	input  wire logic                         ce,
	// AHB-Lite slave
	input  wire logic                         hsel,
	input  wire logic [31:0]                  haddr,
	input  wire logic [1:0]                   htrans,
	input  wire logic                         hwrite,
	input  wire logic [2:0]                   hsize,
	input  wire logic [31:0]                  hwdata,
	input  wire logic                         hready,
	output logic                              hreadyout,
	output logic [31:0]                       hrdata,
	output logic                              hresp,
	// Power state of the processor
	input  wire pcgr_pkg::pcgr_pwr_t          pwr_state,
	// Access to a gated unit and its fault answer
	input  wire pcgr_pkg::pcgr_acc_t          unit_acc,
	output logic                              unit_fault,
	// Clock enables of the gated units
	output logic [pcgr_pkg::NUM_UNITS-1:0]    clk_en,
	// Interrupt
	output logic                              irq
);
	import pcgr_pkg::*;

	// Gating sets: 0 run g0, 1 run g1, 2 sleep g0, 3 sleep g1, 4 deep g0, 5 deep g1
	localparam logic [11:0] GSET_OFF [NUM_GSETS] = '{OFF_RUN_G0, OFF_RUN_G1,
		OFF_SLP_G0, OFF_SLP_G1, OFF_DSL_G0, OFF_DSL_G1};
	localparam logic [31:0] GSET_RST [NUM_GSETS] = '{RST_RUN_G0, RST_RUN_G1,
		RST_SLP_G0, RST_SLP_G1, RST_DSL_G0, RST_DSL_G1};

	// Bus phase tracking
	logic                   dp_q;          // Data phase pending
	logic                   wt_q;          // First data cycle done
	logic [OFF_W-1:0]       addr_q;        // Latched offset
	logic                   wr_q;          // Latched direction
	logic                   accept;        // Address phase taken
	logic                   act;           // Data phase action strobe
	logic [31:0]            rdata_d;       // Read mux
	logic [31:0]            hrdata_q;      // Read data register

	// Register contents
	logic [31:0]            gset_q [NUM_GSETS];  // Gating sets
	logic                   auto_gate_q;         // Auto clock gating
	logic [STS_W-1:0]       sts_q;               // Sticky fault status
	logic [STS_W-1:0]       msk_q;               // Interrupt mask

	// Enable selection
	logic [31:0]            act_g0;        // Applied group 0 set
	logic [31:0]            act_g1;        // Applied group 1 set
	logic [NUM_UNITS-1:0]   en_d;          // Next clock enables
	logic [NUM_UNITS-1:0]   en_q;          // Registered clock enables

	// Fault events
	logic                   unit_ok;       // Unit index in range
	logic                   fault;         // Access to a gated unit
	logic [STS_W-1:0]       sts_set;       // Status set vector
	logic                   sts_rd;        // Status read this cycle

	// Address phase accepted only for active transfers while the bus is ready
	assign accept = hsel & htrans[1] & hready;
	// Action happens in the first data cycle, frozen while ce is low
	assign act    = dp_q & ~wt_q & ce;

	// Bus phase sequencer: one wait cycle, then completion
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dp_q   <= 1'b0;
			wt_q   <= 1'b0;
			addr_q <= 12'h000;
			wr_q   <= 1'b0;
		end else if (ce) begin
			if (accept) begin
				// New transfer starts its data phase
				dp_q   <= 1'b1;
				wt_q   <= 1'b0;
				addr_q <= haddr[OFF_W-1:0];
				wr_q   <= hwrite;
			end else if (dp_q && wt_q) begin
				// Completion cycle over
				dp_q   <= 1'b0;
				wt_q   <= 1'b0;
			end else if (dp_q) begin
				// Wait cycle over
				wt_q   <= 1'b1;
			end
		end
	end

	// Ready low in the wait cycle, high otherwise; always OKAY
	assign hreadyout = ~(dp_q & ~wt_q);
	assign hresp     = 1'b0;

	// Read mux; reserved and unmapped bits read zero
	always_comb begin
		rdata_d = 32'h00000000;
		for (int i = 0; i < NUM_GSETS; i++) begin
			if (addr_q == GSET_OFF[i]) begin
				rdata_d = gset_q[i];
			end
		end
		unique case (addr_q)
			OFF_RUN_CFG: begin
				rdata_d[BIT_AUTO_GATE] = auto_gate_q;
			end
			OFF_IRQ_STS: begin
				rdata_d[STS_W-1:0] = sts_q;
			end
			OFF_IRQ_MSK: begin
				rdata_d[STS_W-1:0] = msk_q;
			end
			default: begin
				// Gating sets handled above, others read zero
			end
		endcase
	end

	// Read data captured in the wait cycle, after any earlier write landed
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			hrdata_q <= 32'h00000000;
		end else if (act && !wr_q) begin
			hrdata_q <= rdata_d;
		end
	end
	assign hrdata = hrdata_q;

	// Gating set registers, one per set; only the unit bits are writable
	generate
		for (genvar g = 0; g < NUM_GSETS; g++) begin : g_gset
			localparam logic [31:0] WMASK = (g % 2 == 0) ? G0_RW_MASK : G1_RW_MASK;
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					gset_q[g] <= GSET_RST[g];
				end else if (act && wr_q && addr_q == GSET_OFF[g]) begin
					gset_q[g] <= hwdata & WMASK;
				end
			end
		end
	endgenerate

	// Run-mode clock configuration register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			auto_gate_q <= 1'b0;
		end else if (act && wr_q && addr_q == OFF_RUN_CFG) begin
			auto_gate_q <= hwdata[BIT_AUTO_GATE];
		end
	end

	// Interrupt mask register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			msk_q <= '0;
		end else if (act && wr_q && addr_q == OFF_IRQ_MSK) begin
			msk_q <= hwdata[STS_W-1:0];
		end
	end

	// Applied set: sleep sets only count when auto gating is on
	always_comb begin
		act_g0 = gset_q[0];
		act_g1 = gset_q[1];
		if (auto_gate_q) begin
			unique case (pwr_state)
				PCGR_PWR_RUN: begin
					// Running: run set
					act_g0 = gset_q[0];
					act_g1 = gset_q[1];
				end
				PCGR_PWR_SLEEP: begin
					// Sleep set
					act_g0 = gset_q[2];
					act_g1 = gset_q[3];
				end
				PCGR_PWR_DEEP: begin
					// Deep-sleep set
					act_g0 = gset_q[4];
					act_g1 = gset_q[5];
				end
				default: begin
					// Illegal code falls back to the run set
					act_g0 = gset_q[0];
					act_g1 = gset_q[1];
				end
			endcase
		end
		// Auto gating off: the defaults above keep the run set in every state
	end

	// Per-unit enable picked from its group and bit
	generate
		for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
			assign en_d[u] = (UNIT_GRP[u] == 0) ? act_g0[UNIT_BIT[u]]
				: act_g1[UNIT_BIT[u]];
		end
	endgenerate

	// Enables registered so a gate cell sees only clock-aligned changes
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			en_q <= '0;
		end else if (ce) begin
			en_q <= en_d;
		end
	end
	assign clk_en = en_q;

	// Fault when the addressed unit has no clock
	assign unit_ok    = unit_acc.unit < UNIT_IDX_W'(NUM_UNITS);
	assign fault      = unit_acc.valid & unit_ok & ~en_q[unit_acc.unit];
	assign unit_fault = fault;

	// Status set vector per group of the faulting unit
	always_comb begin
		sts_set = '0;
		if (fault) begin
			if (unit_acc.unit < UNIT_IDX_W'(3)) begin
				sts_set[STS_FAULT_G0] = 1'b1;
			end else begin
				sts_set[STS_FAULT_G1] = 1'b1;
			end
		end
	end

	// Status read clears the status register
	assign sts_rd = act & ~wr_q & (addr_q == OFF_IRQ_STS);

	// Sticky status: a set in the clearing cycle wins
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sts_q <= '0;
		end else if (ce) begin
			if (sts_rd) begin
				sts_q <= sts_set;
			end else begin
				sts_q <= sts_q | sts_set;
			end
		end
	end

	// Level interrupt while any unmasked status bit is set
	assign irq = |(sts_q & msk_q);

endmodule : pcgr_top
`default_nettype wire
